// >>> include/lpm_pkg.sv
// constants for the low power mode controller
package lpm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAIT_SEL = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_WAKE_INTERVAL = 8'h14;
  // control register fields
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_CMD_W = 2;
  localparam int CTRL_SENSE_EN = 2;
  localparam int CTRL_SENSE_LP = 3;
  localparam int CTRL_W = 4;
  // commands written to the control register
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_WAIT = 2'h1;
  localparam logic [1:0] CMD_ACTIVE_HALT = 2'h2;
  localparam logic [1:0] CMD_HALT = 2'h3;
  // peripheral gate count
  localparam int NUM_PERIPH = 8;
  localparam int SENSE_PERIPH = 7;
  localparam logic [NUM_PERIPH-1:0] WAIT_SEL_RESET = 8'h7F;
  // wakeup timer
  localparam int WAKE_W = 16;
  localparam logic [WAKE_W-1:0] WAKE_INTERVAL_RESET = 16'h0000;
  // irq status bits
  localparam int IRQ_WAKE_TIMER = 0;
  localparam int IRQ_WAKE_SENSE = 1;
  localparam int IRQ_WAKE_EXT = 2;
  localparam int IRQ_W = 3;
  // regulator settling after return to main mode
  localparam int CLK_HZ = 10_000_000;
  localparam int REG_SETTLE_NS = 500;
  localparam int REG_SETTLE_CYC = (REG_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SETTLE_W = 4;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_AHALT_TIMER = 3'b010,
    ST_AHALT_SENSE = 3'b011,
    ST_HALT = 3'b100,
    ST_WAKE = 3'b101
  } lpm_state_t;
endpackage

// >>> hdl/lpm_wake_timer.sv
// wakeup timer counting slow ticks while active-halt waits on it
`timescale 1ns/100ps
module lpm_wake_timer
  import lpm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // control
  input wire logic run_i,
  input wire logic [WAKE_W-1:0] interval_i,
  input wire logic tick_i,
  // result
  output logic expired_o
);
  logic [WAKE_W-1:0] count;
  logic [WAKE_W-1:0] next_count;
  logic next_expired;

  always_comb
  begin
    next_count = count;
    next_expired = 1'b0;
    if (!run_i)
    begin
      next_count = '0;
    end
    else if (tick_i)
    begin
      if (count + 16'h0001 >= interval_i)
      begin
        next_expired = 1'b1;
        next_count = '0;
      end
      else
      begin
        next_count = count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      count <= '0;
      expired_o <= 1'b0;
    end
    else
    begin
      count <= next_count;
      expired_o <= next_expired;
    end
  end
endmodule

// >>> hdl/low_power_mode_controller.sv
// low power mode controller: clock gates, regulator mode, wakeup selection
// How it works
// [RL1] wait stops the cpu clock and keeps the wait-selected peripherals clocked.
// [RL2] active-halt with a wakeup interval stops cpu and all peripheral clocks.
// [RL3] timer active-halt keeps ram retained so its contents survive wakeup.
// [RL4] active-halt entered during an acquisition wakes on sensing interrupts.
// [RL5] that active-halt stops the cpu clock and every peripheral clock except the sensing peripheral's.
// [RL6] halt stops cpu and peripheral clocks while keeping power on.
// [RL7] halt is left only on an external interrupt.
// [RL8] the sensing peripheral may drop to its own low power between conversions.
// [RL9] sensing stays clocked in run, in wait when wait-selected or busy, and in the sensing active-halt.
// [RL10] the debug port clock request is honoured in every state.
// [RL11] halt and active-halt switch to low-consumption regulator unless sensing is on.
// [RL12] an accepted wakeup restores clocks and returns to run.
`timescale 1ns/100ps
module low_power_mode_controller
  import lpm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // wakeup sources and status
  input wire logic wake_tick_i,
  input wire logic sense_busy_i,
  input wire logic sense_irq_i,
  input wire logic ext_irq_i,
  input wire logic sense_converting_i,
  input wire logic debug_active_i,
  // gated clock enables, ram retention, regulator mode, sensing low power and interrupt
  output logic cpu_clk_en_o,
  output logic [NUM_PERIPH-1:0] periph_clk_en_o,
  output logic ram_retain_o,
  output logic main_regulator_mode_o,
  output logic low_consumption_regulator_mode_o,
  output logic sense_low_power_o,
  output logic debug_clk_en_o,
  output logic irq_o
);
  lpm_state_t state;
  lpm_state_t next_state;
  logic [CTRL_W-1:2] cfg;
  logic [CTRL_W-1:2] next_cfg;
  logic [NUM_PERIPH-1:0] wait_sel;
  logic [NUM_PERIPH-1:0] next_wait_sel;
  logic [WAKE_W-1:0] wake_interval;
  logic [WAKE_W-1:0] next_wake_interval;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [SETTLE_W-1:0] settle;
  logic [SETTLE_W-1:0] next_settle;
  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic [31:0] next_hrdata;
  logic timer_expired;
  logic [1:0] cmd;
  logic cmd_strobe;
  logic [IRQ_W-1:0] wake_ev;
  logic next_cpu_en;
  logic [NUM_PERIPH-1:0] next_periph_en;
  logic next_retain;
  logic next_low_consumption_regulator_mode;
  logic addr_take;

  lpm_wake_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .run_i(state == ST_AHALT_TIMER),
    .interval_i(wake_interval),
    .tick_i(wake_tick_i),
    .expired_o(timer_expired)
  );

  // bus: zero wait states, one data phase after the address phase
  assign addr_take = hsel_i && hready_i && htrans_i[1];
  assign cmd_strobe = dp_valid && dp_write && dp_addr == OFS_CTRL;
  assign cmd = hwdata_i[CTRL_CMD_LSB +: CTRL_CMD_W];

  // wakeup events per state
  always_comb
  begin
    wake_ev = '0;
    wake_ev[IRQ_WAKE_TIMER] = state == ST_AHALT_TIMER && timer_expired;
    wake_ev[IRQ_WAKE_SENSE] = state == ST_AHALT_SENSE && sense_irq_i; // [RL4]
    wake_ev[IRQ_WAKE_EXT] = ext_irq_i && (state == ST_HALT || state == ST_WAIT
      || state == ST_AHALT_TIMER || state == ST_AHALT_SENSE); // [RL7]
  end

  always_comb
  begin
    next_state = state;
    next_settle = settle;
    unique case (state)
      ST_RUN:
      begin
        if (cmd_strobe && cmd == CMD_WAIT)
          next_state = ST_WAIT;
        else if (cmd_strobe && cmd == CMD_ACTIVE_HALT)
          next_state = sense_busy_i ? ST_AHALT_SENSE : ST_AHALT_TIMER; // [RL4]
        else if (cmd_strobe && cmd == CMD_HALT)
          next_state = ST_HALT;
      end
      ST_WAIT, ST_AHALT_TIMER, ST_AHALT_SENSE:
      begin
        if (|wake_ev)
        begin
          next_state = ST_WAKE; // [RL12]
          next_settle = SETTLE_W'(REG_SETTLE_CYC);
        end
      end
      ST_HALT:
      begin
        // only the external line can end halt
        if (wake_ev[IRQ_WAKE_EXT])
        begin
          next_state = ST_WAKE; // [RL7]
          next_settle = SETTLE_W'(REG_SETTLE_CYC);
        end
      end
      ST_WAKE:
      begin
        // regulator back in main mode before clocks restart
        if (settle <= 4'h1)
          next_state = ST_RUN; // [RL12]
        else
          next_settle = settle - 4'h1;
      end
      default:
        next_state = ST_RUN;
    endcase
  end

  // gate outputs for the state being entered
  always_comb
  begin
    next_cpu_en = 1'b0;
    next_periph_en = '0;
    next_retain = 1'b1;
    next_low_consumption_regulator_mode = 1'b0;
    unique case (next_state)
      ST_RUN:
      begin
        next_cpu_en = 1'b1; // [RL12]
        next_periph_en = '1;
      end
      // next_ values so a write landing with the command already counts
      ST_WAIT:
      begin
        next_periph_en = next_wait_sel; // [RL1]
        next_periph_en[SENSE_PERIPH] = next_wait_sel[SENSE_PERIPH] | sense_busy_i; // [RL9]
      end
      ST_AHALT_TIMER:
      begin
        next_periph_en = '0; // [RL2]
        next_retain = 1'b1; // [RL3]
        next_low_consumption_regulator_mode = !next_cfg[CTRL_SENSE_EN]; // [RL11]
      end
      ST_AHALT_SENSE:
      begin
        next_periph_en[SENSE_PERIPH] = 1'b1; // [RL5] [RL9]
        next_low_consumption_regulator_mode = !next_cfg[CTRL_SENSE_EN]; // [RL11]
      end
      ST_HALT:
      begin
        next_periph_en = '0; // [RL6]
        next_retain = 1'b1;
        next_low_consumption_regulator_mode = !next_cfg[CTRL_SENSE_EN]; // [RL11]
      end
      ST_WAKE:
        next_low_consumption_regulator_mode = 1'b0;
      default:
        next_cpu_en = 1'b0;
    endcase
  end

  // register writes, reads and sticky status
  always_comb
  begin
    next_cfg = cfg;
    next_wait_sel = wait_sel;
    next_wake_interval = wake_interval;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_hrdata = 32'h0000_0000;
    if (addr_take && !hwrite_i)
    begin
      unique case (haddr_i[7:0])
        OFS_CTRL: next_hrdata = {28'h0, cfg, 2'h0};
        OFS_WAIT_SEL: next_hrdata = {24'h0, wait_sel};
        OFS_STATE: next_hrdata = {29'h0, state};
        OFS_IRQ_STAT: next_hrdata = {29'h0, irq_stat};
        OFS_IRQ_MASK: next_hrdata = {29'h0, irq_mask};
        OFS_WAKE_INTERVAL: next_hrdata = {16'h0, wake_interval};
        default: next_hrdata = 32'h0000_0000;
      endcase
      // read clears; the event merge below lets a new event win
      if (haddr_i[7:0] == OFS_IRQ_STAT)
        next_irq_stat = '0;
    end
    if (dp_valid && dp_write)
    begin
      unique case (dp_addr)
        OFS_CTRL: next_cfg = hwdata_i[CTRL_W-1:2];
        OFS_WAIT_SEL: next_wait_sel = hwdata_i[NUM_PERIPH-1:0];
        OFS_IRQ_MASK: next_irq_mask = hwdata_i[IRQ_W-1:0];
        OFS_WAKE_INTERVAL: next_wake_interval = hwdata_i[WAKE_W-1:0];
        default: next_cfg = cfg;
      endcase
    end
    next_irq_stat = next_irq_stat | wake_ev;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      state <= ST_RUN;
      settle <= '0;
      cfg <= '0;
      wait_sel <= WAIT_SEL_RESET;
      wake_interval <= WAKE_INTERVAL_RESET;
      irq_stat <= '0;
      irq_mask <= '0;
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      cpu_clk_en_o <= 1'b1;
      periph_clk_en_o <= '1;
      ram_retain_o <= 1'b1;
      main_regulator_mode_o <= 1'b1;
      low_consumption_regulator_mode_o <= 1'b0;
      sense_low_power_o <= 1'b0;
      debug_clk_en_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      settle <= next_settle;
      cfg <= next_cfg;
      wait_sel <= next_wait_sel;
      wake_interval <= next_wake_interval;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      dp_valid <= addr_take;
      dp_write <= hwrite_i;
      dp_addr <= haddr_i[7:0];
      hrdata_o <= next_hrdata;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      cpu_clk_en_o <= next_cpu_en;
      periph_clk_en_o <= next_periph_en;
      ram_retain_o <= next_retain;
      main_regulator_mode_o <= !next_low_consumption_regulator_mode; // [RL11]
      low_consumption_regulator_mode_o <= next_low_consumption_regulator_mode; // [RL11]
      // idle between conversions when low power sensing is chosen
      sense_low_power_o <= cfg[CTRL_SENSE_LP] && !sense_converting_i; // [RL8]
      // debug clock is independent of every gate above
      debug_clk_en_o <= debug_active_i; // [RL10]
      irq_o <= |(next_irq_stat & irq_mask);
    end
  end

  chk_wait_gating: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL1]
    state == ST_WAIT |-> !cpu_clk_en_o && (periph_clk_en_o & wait_sel) == wait_sel)
    else $error("wait gating wrong");
  chk_timer_halt_off: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL2]
    state == ST_AHALT_TIMER |-> !cpu_clk_en_o && periph_clk_en_o == '0)
    else $error("timer active-halt clocks running");
  chk_ram_kept: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL3]
    state == ST_AHALT_TIMER |-> ram_retain_o)
    else $error("ram not retained");
  chk_sense_entry: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL4]
    state == ST_RUN && cmd_strobe && cmd == CMD_ACTIVE_HALT && sense_busy_i
    |=> state == ST_AHALT_SENSE)
    else $error("sense active-halt not entered");
  chk_sense_only: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL5]
    state == ST_AHALT_SENSE |-> !cpu_clk_en_o
    && periph_clk_en_o == (8'h01 << SENSE_PERIPH))
    else $error("sense active-halt gating wrong");
  chk_halt_off: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL6]
    state == ST_HALT |-> !cpu_clk_en_o && periph_clk_en_o == '0 && ram_retain_o)
    else $error("halt gating wrong");
  chk_halt_exit: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL7]
    state == ST_HALT && !ext_irq_i |=> state == ST_HALT)
    else $error("halt left without external interrupt");
  chk_regulator: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL11]
    $changed(state) && state == ST_HALT |-> low_consumption_regulator_mode_o
    == !cfg[CTRL_SENSE_EN])
    else $error("regulator mode wrong in halt");
  chk_debug_port: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL10]
    debug_active_i |=> debug_clk_en_o)
    else $error("debug clock refused");
  chk_wake_return: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL12]
    state == ST_HALT && ext_irq_i |=> ##[1:8] state == ST_RUN && cpu_clk_en_o)
    else $error("no return to run");
endmodule

// >>> verif/lpm_gate_partner.sv
// far-side model: slow wakeup tick source and sensing converter
`timescale 1ns/100ps
module lpm_gate_partner
  import lpm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // gates from the controller
  input wire logic [NUM_PERIPH-1:0] periph_clk_en_i,
  // signals back to the controller
  output logic wake_tick_o,
  output logic sense_converting_o
);
  logic [1:0] div;
  logic [3:0] conv;
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      div <= 2'h0;
      conv <= 4'h0;
    end
    else
    begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      // converter only advances while its clock runs
      if (periph_clk_en_i[SENSE_PERIPH])
        conv <= conv + 4'h1;
    end
  end
  assign wake_tick_o = (div == 2'h2);
  assign sense_converting_o = conv[2] & periph_clk_en_i[SENSE_PERIPH];
endmodule

// >>> verif/tb.sv
// self-checking bench for the low power mode controller
`timescale 1ns/100ps
module tb;
  import lpm_pkg::*;
  logic clk_sys_i, reset_i, hsel, hwrite, sense_busy, sense_irq, ext_irq, debug_active;
  logic hrdy, hresp, tick, conv, cpu, ram, rmain, rlow, slp, dbg, irq, mon, dl, cl;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] pen, sel;
  logic [3:0] ctl;
  integer seed, n_fail, checks_done;
  logic [7:0] ra [5] = '{OFS_WAIT_SEL, OFS_STATE, OFS_IRQ_MASK, OFS_WAKE_INTERVAL, 8'h18};
  logic [31:0] rv [5] = '{32'h7F, 32'h0, 32'h0, 32'h0, 32'h0};

  low_power_mode_controller low_power_mode_controller_inst (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .wake_tick_i(tick), .sense_busy_i(sense_busy),
    .sense_irq_i(sense_irq), .ext_irq_i(ext_irq), .sense_converting_i(conv),
    .debug_active_i(debug_active), .cpu_clk_en_o(cpu), .periph_clk_en_o(pen),
    .ram_retain_o(ram), .main_regulator_mode_o(rmain), .low_consumption_regulator_mode_o(rlow),
    .sense_low_power_o(slp), .debug_clk_en_o(dbg), .irq_o(irq));
  lpm_gate_partner lpm_gate_partner_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .periph_clk_en_i(pen), .wake_tick_o(tick), .sense_converting_o(conv));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task results;
    begin
      if (n_fail == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // values read right at the edge are the pre-edge ones the slave drove
  task wait_rdy;
    begin
      @(posedge clk_sys_i);
      while (hrdy !== 1'b1)
        @(posedge clk_sys_i);
      rd = hrdata;
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk_sys_i);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
    end
  endtask

  task settle(input int n);
    begin
      repeat (n) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
    end
  endtask

  task cmd(input logic [1:0] c);
    begin
      bus(1'b1, OFS_CTRL, {28'h0, ctl[3:2], c});
      settle(1);
    end
  endtask

  task wake(input int b);
    int k;
    begin
      k = 0;
      while (cpu !== 1'b1 && k < 60)
      begin
        @(negedge clk_sys_i);
        k = k + 1;
      end
      chk({cpu, pen, rmain, irq}, {1'b1, 8'hFF, 1'b1, 1'b1});
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h1 << b);
      settle(1);
      chk(irq, 1'b0);
      bus(1'b0, OFS_STATE, 32'h0);
      chk(rd, 32'h0);
    end
  endtask

  always @(posedge clk_sys_i)
    if (mon)
      debug_active <= $random(seed);

  // debug clock and sensing low power follow their inputs one edge late
  always @(negedge clk_sys_i)
  begin
    if (mon)
    begin
      chk(dbg, dl);
      chk(slp, ctl[3] & !cl);
    end
    dl = debug_active;
    cl = conv;
  end

  initial
  begin
    #(20000 * 100);
    n_fail = n_fail + 1;
    results();
  end

  initial
  begin
    seed = 95926;
    n_fail = 0;
    checks_done = 0;
    {hsel, hwrite, sense_busy, sense_irq, ext_irq, debug_active, mon} = 7'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    ctl = 4'h8;
    reset_i = 1'b1;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    settle(0);
    chk({cpu, pen, ram, rmain, rlow, irq, hresp}, 14'h3FF8);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    bus(1'b1, OFS_IRQ_MASK, 32'h7);
    cmd(CMD_NONE);
    settle(1);
    mon = 1'b1;
    for (int b = 0; b < 2; b++)
    begin
      sense_busy <= b[0];
      sel = {1'b0, 7'($random(seed))};
      bus(1'b1, OFS_WAIT_SEL, {24'h0, sel});
      cmd(CMD_WAIT);
      chk({cpu, pen}, {1'b0, b[0], sel[6:0]});
      bus(1'b0, OFS_STATE, 32'h0);
      chk(rd, 32'h1);
      @(posedge clk_sys_i) ext_irq <= 1'b1;
      @(posedge clk_sys_i) ext_irq <= 1'b0;
      wake(IRQ_WAKE_EXT);
    end
    sense_busy <= 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      ctl[2] = s[0];
      bus(1'b1, OFS_WAKE_INTERVAL, 32'({$random(seed)} % 4 + 4));
      cmd(CMD_ACTIVE_HALT);
      chk({cpu, pen, ram}, 10'h1);
      chk({rmain, rlow}, {s[0], !s[0]});
      bus(1'b0, OFS_STATE, 32'h0);
      chk(rd, 32'h2);
      wake(IRQ_WAKE_TIMER);
    end
    sense_busy <= 1'b1;
    cmd(CMD_ACTIVE_HALT);
    chk({cpu, pen, rmain, rlow}, 11'h202);
    settle(20);
    chk(cpu, 1'b0);
    @(posedge clk_sys_i) sense_irq <= 1'b1;
    @(posedge clk_sys_i) sense_irq <= 1'b0;
    sense_busy <= 1'b0;
    wake(IRQ_WAKE_SENSE);
    ctl[2] = 1'b0;
    cmd(CMD_HALT);
    chk({cpu, pen, ram, rlow}, 11'h3);
    @(posedge clk_sys_i) sense_irq <= 1'b1;
    @(posedge clk_sys_i) sense_irq <= 1'b0;
    settle(20);
    chk({cpu, pen}, 9'h0);
    @(posedge clk_sys_i) ext_irq <= 1'b1;
    @(posedge clk_sys_i) ext_irq <= 1'b0;
    wake(IRQ_WAKE_EXT);
    results();
  end
endmodule
